// ===== sim/ai_acquisition_sequencer_tb.sv
`timescale 1ns/100ps
module ai_acquisition_sequencer_tb;
  import aqs_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  aqs_cfg_t cfg;
  logic [CNT_W-1:0] cnt;
  logic [DIV_W-1:0] div;
  logic [5:0] cmd;
  logic ext, dstart, dref, dpause, acmp, rdy;
  logic conv_start, conv_done, dvalid, dlast;
  logic [DATA_W-1:0] cdata;
  logic [2*DATA_W-1:0] ddata;
  aqs_status_t st;
  int mismatches, comparisons, convs, beats, c0, c1, rm, cyc;
  bit track, have;
  logic [31:0] q[$];
  logic [15:0] half;

  initial begin
    forever #20 clk = ~clk;
  end

  aqs_sequencer dut_u (.clk_in(clk), .nrst_in(nrst), .cfg_in(cfg), .sample_count_in(cnt),
    .clk_div_in(div), .go_in(cmd[0]), .stop_in(cmd[1]), .convert_cmd_in(cmd[2]),
    .single_point_read_in(cmd[3]), .ovf_clear_in(cmd[4]), .late_clear_in(cmd[5]),
    .ext_sample_clk_in(ext), .dig_start_in(dstart), .dig_ref_in(dref), .dig_pause_in(dpause),
    .analog_cmp_in(acmp), .conv_start_out(conv_start), .conv_done_in(conv_done),
    .conv_data_in(cdata), .dma_valid_out(dvalid), .dma_data_out(ddata), .dma_last_out(dlast),
    .dma_ready_in(rdy), .status_out(st));

  aqs_front_model #(.LAT(3)) part_u (.clk_in(clk), .conv_start_in(conv_start),
    .conv_done_out(conv_done), .conv_data_out(cdata));

  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic pulse(int i);
    @(negedge clk);
    cmd[i] = 1'b1;
    @(negedge clk);
    cmd[i] = 1'b0;
  endtask

  task automatic run(aqs_mode_t m, int n, int d);
    cfg.mode = m;
    cnt = CNT_W'(n);
    div = DIV_W'(d);
    pulse(0);
  endtask

  task automatic wait_idle();
    repeat (4) @(negedge clk);
    for (int i = 0; i < 3000; i++) begin
      if (st.busy === 1'b0) break;
      @(negedge clk);
    end
    // Margin for converter latency and DMA drain under stalls
    repeat (30) @(negedge clk);
  endtask

  // Ready: 0 stalls, 1 always, 2 random
  always @(negedge clk) begin
    rdy <= (rm == 2) ? ($urandom % 3 != 0) : (rm == 1);
  end

  // Scoreboard: expected words noted from converter data, taken off at each beat
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
    if (conv_start === 1'b1) convs++;
    if (track && conv_done === 1'b1) begin
      if (cfg.pair_xfer) begin
        if (have) q.push_back({cdata, half});
        else half = cdata;
        have = !have;
      end else begin
        q.push_back({16'h0000, cdata});
      end
    end
    if (dvalid === 1'b1 && rdy === 1'b1) begin
      if (track) begin
        chk("dma_data", ddata, (q.size() > 0) ? q.pop_front() : 32'hXXXXXXXX);
        chk("dma_last", dlast, beats % 8 == 7);
      end
      beats++;
    end
  end

  initial begin
    cfg = '0;
    cnt = '0;
    div = '0;
    cmd = '0;
    {ext, dstart, dref, dpause, acmp} = 5'h00;
    rm = 1;
    void'($urandom(327));
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    ////////////////////////////////////////////////////////////
    track = 1;
    rm = 2;
    run(AQS_FINITE, 16, 1);
    wait_idle();
    chk("beats", beats, 16);
    cfg.pair_xfer = 1'b1;
    run(AQS_FINITE, 5, 1);
    wait_idle();
    chk("pair_beats", beats, 18);
    chk("odd_left", {31'h0, have}, 1);
    track = 0;
    cfg.pair_xfer = 1'b0;
    rm = 1;
    ////////////////////////////////////////////////////////////
    cfg.mode = AQS_ON_DEMAND;
    c0 = convs;
    repeat (3) pulse(2);
    pulse(0);
    repeat (4) @(negedge clk);
    chk("on_demand", convs - c0, 3);
    chk("od_busy", st.busy, 0);
    for (int i = 0; i < 2; i++) begin
      c1 = 2 + $urandom % 5;
      c0 = convs;
      run(AQS_FINITE, c1, $urandom % 3);
      wait_idle();
      chk("finite", convs - c0, c1);
      chk("done", st.done, 1);
    end
    cfg.ext_clk_sel = 1'b1;
    c0 = convs;
    run(AQS_FINITE, 4, 0);
    repeat (4) begin
      repeat (3) @(negedge clk);
      ext = 1'b1;
      repeat (3) @(negedge clk);
      ext = 1'b0;
    end
    wait_idle();
    chk("ext_clk", convs - c0, 4);
    cfg.ext_clk_sel = 1'b0;
    ////////////////////////////////////////////////////////////
    for (int a = 0; a < 2; a++) begin
      cfg.start_trig_en = 1'b1;
      cfg.start_trig_analog = a[0];
      c0 = convs;
      run(AQS_FINITE, 3, 1);
      repeat (20) @(negedge clk);
      chk("pre_start", convs - c0, 0);
      if (a == 1) acmp = 1'b1;
      else dstart = 1'b1;
      repeat (6) @(negedge clk);
      {acmp, dstart} = 2'h0;
      wait_idle();
      chk("started", convs - c0, 3);
    end
    cfg.start_trig_en = 1'b0;
    for (int p = 0; p < 2; p++) begin
      cfg.pause_en = 1'b1;
      cfg.pause_active_high = p[0];
      dpause = p[0];
      c0 = convs;
      run(AQS_CONTINUOUS, 2, 0);
      repeat (20) @(negedge clk);
      chk("paused", convs - c0, 0);
      dpause = !p[0];
      repeat (20) @(negedge clk);
      chk("resumed", convs - c0 > 10, 1);
      pulse(1);
      wait_idle();
    end
    cfg.pause_en = 1'b0;
    cfg.ref_trig_en = 1'b1;
    run(AQS_FINITE, 3, 0);
    repeat (10) @(negedge clk);
    chk("pre_ref", st.busy, 1);
    c1 = convs;
    dref = 1'b1;
    wait_idle();
    dref = 1'b0;
    // Three post-trigger samples plus pin sync, edge detect and output register
    chk("ref_post", convs - c1, 7);
    chk("ref_done", st.done, 1);
    ////////////////////////////////////////////////////////////
    cfg.ref_trig_en = 1'b0;
    c0 = convs;
    run(AQS_CONTINUOUS, 2, 0);
    repeat (30) @(negedge clk);
    pulse(1);
    repeat (3) @(negedge clk);
    c1 = convs;
    chk("no_limit", c1 - c0 > 20, 1);
    repeat (10) @(negedge clk);
    chk("stopped", convs, c1);
    wait_idle();
    rm = 0;
    run(AQS_CONTINUOUS, 2, 0);
    repeat (40) @(negedge clk);
    pulse(1);
    repeat (3) @(negedge clk);
    chk("overflow", st.overflow, 1);
    repeat (5) @(negedge clk);
    chk("ovf_held", st.overflow, 1);
    pulse(4);
    repeat (2) @(negedge clk);
    chk("ovf_clr", st.overflow, 0);
    rm = 1;
    wait_idle();
    run(AQS_HW_SINGLE_POINT, 2, 3);
    repeat (20) @(negedge clk);
    pulse(1);
    repeat (3) @(negedge clk);
    chk("late", st.late, 1);
    pulse(5);
    repeat (2) @(negedge clk);
    chk("late_clr", st.late, 0);
    // Reads every two cycles against a tick every sixteen: never late
    run(AQS_HW_SINGLE_POINT, 2, 15);
    repeat (12) pulse(3);
    pulse(1);
    repeat (3) @(negedge clk);
    chk("not_late", st.late, 0);
    complete_run();
  end
endmodule

// ===== sim/aqs_front_model.sv
`timescale 1ns/100ps
// Converter front end: fixed latency, accepts a start every cycle
module aqs_front_model
#(
  parameter int LAT = 3
)
(
  // Clock
  input wire logic clk_in,
  // Converter handshake
  input wire logic conv_start_in,
  output logic conv_done_out,
  output logic [aqs_pkg::DATA_W-1:0] conv_data_out
);
  import aqs_pkg::*;
  logic [LAT-1:0] pipe = '0;
  logic [DATA_W-1:0] q[$];
  initial conv_done_out = 1'b0;
  initial conv_data_out = 16'h0000;
  always @(posedge clk_in) begin
    pipe <= {pipe[LAT-2:0], conv_start_in === 1'b1};
    conv_done_out <= pipe[LAT-1];
    if (conv_start_in === 1'b1) begin
      q.push_back(DATA_W'($urandom));
    end
    // Idle data bus toggles so a stale value is never mistaken for fresh
    if (pipe[LAT-1] && q.size() > 0) begin
      conv_data_out <= q.pop_front();
    end else begin
      conv_data_out <= ~conv_data_out;
    end
  end
endmodule

// ===== src/aqs_fifo.sv
`timescale 1ns/100ps
// Overwriting FIFO: a write when full drops the oldest word
module aqs_fifo
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_sync_in,
  // Write side
  input wire logic wr_in,
  input wire logic [aqs_pkg::DATA_W-1:0] wdata_in,
  // Read side
  input wire logic rd_in,
  output logic [aqs_pkg::DATA_W-1:0] rdata_out,
  // Status
  output logic [aqs_pkg::FIFO_AW:0] level_out,
  output logic ovf_out
);
  import aqs_pkg::*;
  localparam logic [FIFO_AW:0] FULL = 5'h10;
  logic [DATA_W-1:0] mem [0:(1<<FIFO_AW)-1];
  logic [FIFO_AW-1:0] wp;
  logic [FIFO_AW-1:0] rp;
  logic full;
  logic do_rd;

  assign full = (level_out == FULL);
  assign do_rd = rd_in && (level_out != LVL_RST);
  assign rdata_out = mem[rp];
  assign ovf_out = wr_in && full && !do_rd;

  always_ff @(posedge clk_in) begin
    if (wr_in) begin
      mem[wp] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_sync_in) begin
    if (!nrst_sync_in) begin
      wp <= '0;
      rp <= '0;
      level_out <= LVL_RST;
    end else begin
      if (wr_in) begin
        wp <= wp + 1'b1;
      end
      if (do_rd || (wr_in && full)) begin
        rp <= rp + 1'b1;
      end
      if (wr_in && !full && !do_rd) begin
        level_out <= level_out + 1'b1;
      end else if (do_rd && !wr_in) begin
        level_out <= level_out - 1'b1;
      end
    end
  end
endmodule

// ===== src/aqs_pkg.sv
// Behaviour
// - In on-demand timing each distinct host command starts exactly one conversion.
// - In hardware-timed operation each sample is paced by a selectable internal or external sample clock.
// - In finite mode the device counts samples and stops by itself when the programmed count is reached.
// - In pair-transfer mode samples move two at a time and a final odd sample is not transferred.
// - In continuous mode acquisition goes on with no limit until the host commands a stop.
// - A sample arriving while the FIFO is full overwrites old data and raises an overflow error.
// - Buffered acquisition moves data from the FIFO to host memory in DMA block transfers.
// - In hardware-timed single point the device flags lateness when software misses a sample clock tick.
// - The controller offers a start trigger, a reference trigger and a pause trigger.
// - Each trigger is selectable from a digital source or an analog comparison source.
// - While the pause trigger is active the internal sample clock is held, resuming when it goes inactive.
// - The pause trigger is a level with programmable polarity, never an edge.
package aqs_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned FIFO_AW = 4;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned BLOCK_LEN = 8;
  localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
  localparam logic [DIV_W-1:0] DIV_RST = 16'h0000;
  localparam logic [FIFO_AW:0] LVL_RST = 5'h00;

  typedef enum logic [1:0] {AQS_ON_DEMAND, AQS_FINITE, AQS_CONTINUOUS, AQS_HW_SINGLE_POINT} aqs_mode_t;
  typedef enum {AQS_IDLE, AQS_ARMED, AQS_RUN, AQS_POST} aqs_state_t;

  typedef struct packed {
    aqs_mode_t mode;
    logic ext_clk_sel;
    logic pair_xfer;
    logic start_trig_en;
    logic start_trig_analog;
    logic ref_trig_en;
    logic ref_trig_analog;
    logic pause_en;
    logic pause_analog;
    logic pause_active_high;
  } aqs_cfg_t;

  typedef struct packed {
    logic overflow;
    logic late;
    logic busy;
    logic done;
  } aqs_status_t;
endpackage

// ===== src/aqs_sequencer.sv
`timescale 1ns/100ps
module aqs_sequencer
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Configuration
  input wire aqs_pkg::aqs_cfg_t cfg_in,
  input wire logic [aqs_pkg::CNT_W-1:0] sample_count_in,
  input wire logic [aqs_pkg::DIV_W-1:0] clk_div_in,
  // Host commands, one-cycle pulses
  input wire logic go_in,
  input wire logic stop_in,
  input wire logic convert_cmd_in,
  input wire logic single_point_read_in,
  input wire logic ovf_clear_in,
  input wire logic late_clear_in,
  // Pins from outside
  input wire logic ext_sample_clk_in,
  input wire logic dig_start_in,
  input wire logic dig_ref_in,
  input wire logic dig_pause_in,
  input wire logic analog_cmp_in,
  // Converter front end
  output logic conv_start_out,
  input wire logic conv_done_in,
  input wire logic [aqs_pkg::DATA_W-1:0] conv_data_in,
  // DMA block path
  output logic dma_valid_out,
  output logic [2*aqs_pkg::DATA_W-1:0] dma_data_out,
  output logic dma_last_out,
  input wire logic dma_ready_in,
  // Status
  output aqs_pkg::aqs_status_t status_out
);
  import aqs_pkg::*;
  ////////////////////////////////////////////////////////////
  logic rst_s1, rst_n;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Two-stage synchronisers for all pin inputs
  logic [4:0] pin_s1, pin_s2, pin_d;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_d <= '0;
    end else begin
      pin_s1 <= {ext_sample_clk_in, dig_start_in, dig_ref_in, dig_pause_in, analog_cmp_in};
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  logic ext_clk_rise, start_lvl, start_rise, ref_lvl, ref_rise, pause_src, paused;
  assign ext_clk_rise = pin_s2[4] && !pin_d[4];
  assign start_lvl = cfg_in.start_trig_analog ? pin_s2[0] : pin_s2[3];
  assign start_rise = start_lvl && !(cfg_in.start_trig_analog ? pin_d[0] : pin_d[3]);
  assign ref_lvl = cfg_in.ref_trig_analog ? pin_s2[0] : pin_s2[2];
  assign ref_rise = ref_lvl && !(cfg_in.ref_trig_analog ? pin_d[0] : pin_d[2]);
  assign pause_src = cfg_in.pause_analog ? pin_s2[0] : pin_s2[1];
  // Level compare only, so a held pause never slips a tick
  assign paused = cfg_in.pause_en && (pause_src == cfg_in.pause_active_high);

  ////////////////////////////////////////////////////////////
  aqs_state_t state;
  logic [CNT_W-1:0] remain;
  logic [DIV_W-1:0] div_cnt;
  logic int_tick, tick, running, timed, finite_end;

  assign timed = (cfg_in.mode != AQS_ON_DEMAND);
  assign running = (state == AQS_RUN) || (state == AQS_POST);
  // Internal divider held while paused
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= DIV_RST;
    end else if (!running || paused) begin
      div_cnt <= div_cnt;
    end else if (div_cnt >= clk_div_in) begin
      div_cnt <= DIV_RST;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  assign int_tick = running && !paused && (div_cnt >= clk_div_in);
  assign tick = timed && running && !paused && (cfg_in.ext_clk_sel ? ext_clk_rise : int_tick);

  logic finite_like;
  assign finite_like = (cfg_in.mode == AQS_FINITE);
  assign finite_end = finite_like && running && tick && (remain == CNT_W'(1));

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= AQS_IDLE;
      remain <= CNT_RST;
    end else begin
      case (state)
        AQS_IDLE: begin
          if (go_in && timed) begin
            remain <= sample_count_in;
            state <= cfg_in.start_trig_en ? AQS_ARMED : AQS_RUN;
          end
        end
        AQS_ARMED: begin
          if (stop_in) begin
            state <= AQS_IDLE;
          end else if (start_rise) begin
            state <= AQS_RUN;
          end
        end
        AQS_RUN: begin
          if (stop_in) begin
            state <= AQS_IDLE;
          end else if (finite_like && cfg_in.ref_trig_en && ref_rise) begin
            state <= AQS_POST;
          end else if (finite_end) begin
            state <= AQS_IDLE;
          end else if (tick && finite_like && !cfg_in.ref_trig_en) begin
            remain <= remain - 1'b1;
          end
        end
        AQS_POST: begin
          // Post-trigger samples counted down from the programmed count
          if (stop_in || finite_end) begin
            state <= AQS_IDLE;
          end else if (tick) begin
            remain <= remain - 1'b1;
          end
        end
        default: state <= AQS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // One conversion per command or per tick
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      conv_start_out <= 1'b0;
    end else begin
      conv_start_out <= (cfg_in.mode == AQS_ON_DEMAND) ? convert_cmd_in : tick;
    end
  end

  // Single-point lateness: tick while previous sample unread
  logic pending, late_set;
  assign late_set = (cfg_in.mode == AQS_HW_SINGLE_POINT) && tick && pending && !single_point_read_in;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pending <= 1'b0;
    end else if (tick && cfg_in.mode == AQS_HW_SINGLE_POINT) begin
      pending <= 1'b1;
    end else if (single_point_read_in || !running) begin
      pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  logic fifo_wr, fifo_rd, fifo_ovf;
  logic [DATA_W-1:0] fifo_q;
  logic [FIFO_AW:0] fifo_lvl;
  assign fifo_wr = conv_done_in && (cfg_in.mode == AQS_FINITE || cfg_in.mode == AQS_CONTINUOUS);

  aqs_fifo u_fifo (
    .clk_in(clk_in),
    .nrst_sync_in(rst_n),
    .wr_in(fifo_wr),
    .wdata_in(conv_data_in),
    .rd_in(fifo_rd),
    .rdata_out(fifo_q),
    .level_out(fifo_lvl),
    .ovf_out(fifo_ovf)
  );

  // Packer: pair mode needs two words; lone last word is left behind
  logic half, pair_mode, have_word, beat;
  logic [DATA_W-1:0] low_word;
  logic [3:0] beat_cnt;
  assign pair_mode = cfg_in.pair_xfer;
  assign have_word = (fifo_lvl != LVL_RST);
  assign fifo_rd = have_word && (!dma_valid_out || dma_ready_in) && (pair_mode || !half);
  assign beat = fifo_rd && (!pair_mode || half);

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      half <= 1'b0;
      low_word <= '0;
      dma_valid_out <= 1'b0;
      dma_data_out <= '0;
      dma_last_out <= 1'b0;
      beat_cnt <= 4'h0;
    end else begin
      if (fifo_rd && pair_mode && !half) begin
        low_word <= fifo_q;
        half <= 1'b1;
      end else if (beat) begin
        half <= 1'b0;
      end else if (!pair_mode || (state == AQS_IDLE && go_in)) begin
        // Leftover dropped at next start or when pair mode is off: late words still arrive after idle
        half <= 1'b0;
      end
      if (beat) begin
        dma_valid_out <= 1'b1;
        dma_data_out <= pair_mode ? {fifo_q, low_word} : {{DATA_W{1'b0}}, fifo_q};
        dma_last_out <= (beat_cnt == 4'(BLOCK_LEN - 1));
        beat_cnt <= (beat_cnt == 4'(BLOCK_LEN - 1)) ? 4'h0 : beat_cnt + 1'b1;
      end else if (dma_ready_in) begin
        dma_valid_out <= 1'b0;
        dma_last_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Sticky overflow, late and done flags, set wins over clear; busy follows state
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      status_out <= '0;
    end else begin
      status_out.overflow <= fifo_ovf || (status_out.overflow && !ovf_clear_in);
      status_out.late <= late_set || (status_out.late && !late_clear_in);
      status_out.busy <= running || (state == AQS_ARMED);
      status_out.done <= finite_end || (status_out.done && !go_in);
    end
  end

  ////////////////////////////////////////////////////////////
  property p_ovf_sticky;
    @(posedge clk_in) disable iff (!rst_n) fifo_ovf |=> status_out.overflow;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow not flagged");

  property p_ovf_hold;
    @(posedge clk_in) disable iff (!rst_n) status_out.overflow && !ovf_clear_in |=> status_out.overflow;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow dropped without clear");

  property p_on_demand;
    @(posedge clk_in) disable iff (!rst_n)
      cfg_in.mode == AQS_ON_DEMAND && $stable(cfg_in) |=> conv_start_out == $past(convert_cmd_in);
  endproperty
  a_on_demand: assert property (p_on_demand) else $error("conversion not one per command");

  property p_pause_hold;
    @(posedge clk_in) disable iff (!rst_n) timed && paused |=> !conv_start_out;
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("tick while paused");

  property p_finite_stop;
    @(posedge clk_in) disable iff (!rst_n) finite_end && !stop_in |=> state == AQS_IDLE ##1 !conv_start_out;
  endproperty
  a_finite_stop: assert property (p_finite_stop) else $error("finite run did not stop");

  property p_reload;
    @(posedge clk_in) disable iff (!rst_n) state == AQS_IDLE && go_in && timed |=> remain == $past(sample_count_in);
  endproperty
  a_reload: assert property (p_reload) else $error("count not reloaded");

  property p_late;
    @(posedge clk_in) disable iff (!rst_n) late_set |=> status_out.late;
  endproperty
  a_late: assert property (p_late) else $error("lateness not flagged");

  property p_cont_runs;
    @(posedge clk_in) disable iff (!rst_n)
      state == AQS_RUN && cfg_in.mode == AQS_CONTINUOUS && !stop_in && $stable(cfg_in) |=> state == AQS_RUN;
  endproperty
  a_cont_runs: assert property (p_cont_runs) else $error("continuous run ended without stop");

  property p_start_trig;
    @(posedge clk_in) disable iff (!rst_n) state == AQS_ARMED && start_rise && !stop_in |=> state == AQS_RUN;
  endproperty
  a_start_trig: assert property (p_start_trig) else $error("start trigger missed");

  c_finite_done: cover property (@(posedge clk_in) disable iff (!rst_n) finite_end);
  c_overflow: cover property (@(posedge clk_in) disable iff (!rst_n) fifo_ovf);
  c_paused_run: cover property (@(posedge clk_in) disable iff (!rst_n) running && paused);
  c_dma_last: cover property (@(posedge clk_in) disable iff (!rst_n) dma_valid_out && dma_last_out);
endmodule
